// ### inc/adc_seq_pkg.sv
// constants, field layouts and types for the conversion sequencer
package adc_seq_pkg;
    // ****************************************************
    // register byte offsets
    // ****************************************************
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] INJ_OFF = 12'h004;
    localparam logic [11:0] SEQ_OFF = 12'h008;
    localparam logic [11:0] WDTHR_OFF = 12'h00C;
    localparam logic [11:0] WDMASK_OFF = 12'h010;
    localparam logic [11:0] STATUS_OFF = 12'h014;
    localparam logic [11:0] IMASK_OFF = 12'h018;
    localparam logic [11:0] DATA_OFF = 12'h01C;
    localparam logic [11:0] JDATA_OFF = 12'h020;
    localparam logic [11:0] ROUTE_OFF = 12'h024;
    localparam logic [11:0] CAL0_OFF = 12'h028;
    localparam logic [11:0] CAL1_OFF = 12'h02C;

    // ****************************************************
    // sizes, channels and field positions
    // ****************************************************
    localparam int RES_BITS = 12;
    localparam int CHAN_BITS = 6;
    localparam int EXT_CHANNELS = 40;
    localparam int SEQ_DEPTH = 28;
    localparam int TRIG_NUM = 8;
    localparam logic [4:0] SEQ_LAST_POS = 5'h1B;
    localparam logic [5:0] TS_CHANNEL = 6'h10;
    localparam logic [5:0] VREF_CHANNEL = 6'h11;
    localparam int ST_EOC = 0;
    localparam int ST_EOS = 1;
    localparam int ST_JEOC = 2;
    localparam int ST_AWD = 3;
    localparam int INJ_GO_BIT = 8;
    localparam int SEQ_CHAN_LSB = 8;
    localparam int THR_HIGH_LSB = 16;
    localparam int ROUTE_TS = 0;
    localparam int ROUTE_VREF = 1;
    localparam logic [1:0] WD_OFF = 2'b00;
    localparam logic [1:0] WD_SINGLE = 2'b01;
    localparam logic [1:0] WD_SUBSET = 2'b10;
    localparam logic [1:0] WD_ALL = 2'b11;

    // ****************************************************
    // reset values and timing
    // ****************************************************
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] WDTHR_RST = 32'h0FFF_0000;
    localparam int CLK_HZ = 20_000_000;
    localparam int PWRUP_NS = 1000;
    localparam int PWRUP_CYC = (PWRUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // control register layout
    typedef struct packed {
        logic [5:0] wd_chan;
        logic [1:0] wd_mode;
        logic [2:0] rsvd1;
        logic [4:0] scan_last;
        logic [4:0] rsvd0;
        logic [2:0] trig_sel;
        logic trig_en;
        logic low_power;
        logic auto_off;
        logic dma_en;
        logic scan;
        logic start;
        logic rsvd;
        logic enable;
    } ctrl_type;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PWRUP = 2'b01,
        ST_START = 2'b10,
        ST_WAIT = 2'b11
    } seq_state_type;
endpackage

// ### rtl/adc_sequencer_control.sv
// conversion sequencer with apb registers, injection, watchdog and dma
`timescale 1ns/1ps

module adc_sequencer_control #(
    parameter logic [31:0] CAL_TS_WORD = 32'h0123_0456, // arbitrary value
    parameter logic [31:0] CAL_VREF_WORD = 32'h0000_0789 // arbitrary value
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [adc_seq_pkg::TRIG_NUM-1:0] trig_i,
    output logic conv_start_o,
    output logic conv_abort_o,
    output logic [adc_seq_pkg::CHAN_BITS-1:0] conv_chan_o,
    input wire logic conv_done_i,
    input wire logic [adc_seq_pkg::RES_BITS-1:0] conv_data_i,
    output logic adc_power_o,
    output logic low_power_o,
    output logic route_ts_o,
    output logic route_vref_o,
    output logic dma_req_o,
    input wire logic dma_ack_i,
    output logic irq_o
);
    // ****************************************************
    // state
    // ****************************************************
    adc_seq_pkg::ctrl_type ctrl_q, ctrl_d;
    adc_seq_pkg::seq_state_type st_q, st_d;
    logic [5:0] seq_q [adc_seq_pkg::SEQ_DEPTH];
    logic [5:0] seq_d [adc_seq_pkg::SEQ_DEPTH];
    logic [5:0] inj_chan_q, inj_chan_d;
    logic [11:0] thr_lo_q, thr_lo_d, thr_hi_q, thr_hi_d;
    logic [27:0] wd_mask_q, wd_mask_d;
    logic [3:0] status_q, status_d, imask_q, imask_d;
    logic [11:0] data_q, data_d, jdata_q, jdata_d;
    logic data_vld_q, data_vld_d;
    logic [1:0] route_q, route_d;
    logic reg_pend_q, reg_pend_d, inj_pend_q, inj_pend_d;
    logic scan_act_q, scan_act_d, cur_inj_q, cur_inj_d;
    logic [4:0] pos_q, pos_d;
    logic [7:0] cnt_q, cnt_d;
    logic pwr_q, pwr_d, start_q, start_d, abort_q, abort_d;
    logic [5:0] chan_q, chan_d;
    logic [31:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;
    logic wr, rd_acc, setup;
    logic [3:0] st_set, st_clr;
    logic [4:0] last_pos;

    // watchdog window test on one result
    function automatic logic out_of_window(input logic [11:0] v,
            input logic [11:0] lo, input logic [11:0] hi);
        out_of_window = (v < lo) || (v > hi);
    endfunction

    // address match used by both read and write decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    // ****************************************************
    // outputs
    // ****************************************************
    assign pready_o = 1'b1;
    assign prdata_o = rdata_q;
    assign pslverr_o = slverr_q;
    assign conv_start_o = start_q;
    assign conv_abort_o = abort_q;
    assign conv_chan_o = chan_q;
    assign adc_power_o = pwr_q;
    assign low_power_o = ctrl_q.low_power;
    assign route_ts_o = route_q[adc_seq_pkg::ROUTE_TS];
    assign route_vref_o = route_q[adc_seq_pkg::ROUTE_VREF];
    assign dma_req_o = data_vld_q && ctrl_q.dma_en;
    assign irq_o = |(status_q & imask_q);

    assign wr = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign setup = psel_i && !penable_i;
    // single mode converts slot 0 only; scan length is clamped
    assign last_pos = !ctrl_q.scan ? 5'h00 :
        (ctrl_q.scan_last > adc_seq_pkg::SEQ_LAST_POS) ?
        adc_seq_pkg::SEQ_LAST_POS : ctrl_q.scan_last;

    // ****************************************************
    // next-state logic
    // ****************************************************
    always_comb begin
        ctrl_d = ctrl_q;
        st_d = st_q;
        seq_d = seq_q;
        inj_chan_d = inj_chan_q;
        thr_lo_d = thr_lo_q;
        thr_hi_d = thr_hi_q;
        wd_mask_d = wd_mask_q;
        imask_d = imask_q;
        data_d = data_q;
        jdata_d = jdata_q;
        data_vld_d = data_vld_q;
        route_d = route_q;
        reg_pend_d = reg_pend_q;
        inj_pend_d = inj_pend_q;
        scan_act_d = scan_act_q;
        cur_inj_d = cur_inj_q;
        pos_d = pos_q;
        cnt_d = cnt_q;
        pwr_d = pwr_q;
        start_d = 1'b0;
        abort_d = 1'b0;
        chan_d = chan_q;
        st_set = 4'h0;
        st_clr = 4'h0;
        rdata_d = rdata_q;
        slverr_d = 1'b0;
        // result read or dma acknowledge retires the pending result
        if ((rd_acc && hit(paddr_i, adc_seq_pkg::DATA_OFF)) || dma_ack_i) begin
            data_vld_d = 1'b0;
        end
        // sequencer
        case (st_q)
            adc_seq_pkg::ST_IDLE: begin
                if (!ctrl_q.enable) begin
                    reg_pend_d = 1'b0;
                    inj_pend_d = 1'b0;
                    scan_act_d = 1'b0;
                    pos_d = 5'h00;
                    pwr_d = 1'b0;
                end else if (reg_pend_q || inj_pend_q || scan_act_q) begin
                    if (pwr_q) begin
                        st_d = adc_seq_pkg::ST_START;
                    end else begin
                        pwr_d = 1'b1;
                        cnt_d = 8'(adc_seq_pkg::PWRUP_CYC - 1);
                        st_d = adc_seq_pkg::ST_PWRUP;
                    end
                end else begin
                    pwr_d = !ctrl_q.auto_off;
                end
            end
            adc_seq_pkg::ST_PWRUP: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    st_d = adc_seq_pkg::ST_START;
                end
            end
            adc_seq_pkg::ST_START: begin
                if (inj_pend_q) begin
                    cur_inj_d = 1'b1;
                    chan_d = inj_chan_q;
                    inj_pend_d = 1'b0;
                    start_d = 1'b1;
                    st_d = adc_seq_pkg::ST_WAIT;
                end else if (reg_pend_q || scan_act_q) begin
                    cur_inj_d = 1'b0;
                    chan_d = seq_q[pos_q];
                    reg_pend_d = 1'b0;
                    scan_act_d = 1'b1;
                    start_d = 1'b1;
                    st_d = adc_seq_pkg::ST_WAIT;
                end else begin
                    st_d = adc_seq_pkg::ST_IDLE;
                end
            end
            adc_seq_pkg::ST_WAIT: begin
                if (conv_done_i) begin
                    // watchdog, once per completed result
                    if (((ctrl_q.wd_mode == adc_seq_pkg::WD_SINGLE) &&
                            (chan_q == ctrl_q.wd_chan)) ||
                        ((ctrl_q.wd_mode == adc_seq_pkg::WD_SUBSET) &&
                            !cur_inj_q && wd_mask_q[pos_q]) ||
                        ((ctrl_q.wd_mode == adc_seq_pkg::WD_ALL) &&
                            !cur_inj_q)) begin
                        if (out_of_window(conv_data_i, thr_lo_q, thr_hi_q)) begin
                            st_set[adc_seq_pkg::ST_AWD] = 1'b1;
                        end
                    end
                    if (cur_inj_q) begin
                        jdata_d = conv_data_i;
                        st_set[adc_seq_pkg::ST_JEOC] = 1'b1;
                    end else begin
                        data_d = conv_data_i;
                        data_vld_d = 1'b1;
                        st_set[adc_seq_pkg::ST_EOC] = 1'b1;
                        if (pos_q < last_pos) begin
                            pos_d = pos_q + 5'h01;
                        end else begin
                            pos_d = 5'h00;
                            scan_act_d = 1'b0;
                            st_set[adc_seq_pkg::ST_EOS] = ctrl_q.scan;
                        end
                    end
                    st_d = adc_seq_pkg::ST_START;
                end else if (!cur_inj_q && inj_pend_q) begin
                    abort_d = 1'b1;
                    st_d = adc_seq_pkg::ST_START; // slot kept
                end
            end
            default: begin
                st_d = adc_seq_pkg::ST_IDLE;
            end
        endcase
        // timer event start
        if (ctrl_q.enable && ctrl_q.trig_en && trig_i[ctrl_q.trig_sel]) begin
            reg_pend_d = 1'b1;
        end
        // register writes
        if (wr) begin
            if (hit(paddr_i, adc_seq_pkg::CTRL_OFF)) begin
                ctrl_d = adc_seq_pkg::ctrl_type'(pwdata_i);
                ctrl_d.start = 1'b0;
                ctrl_d.rsvd = 1'b0;
                ctrl_d.rsvd0 = 5'h00;
                ctrl_d.rsvd1 = 3'h0;
                if (pwdata_i[2] && pwdata_i[0]) begin
                    reg_pend_d = 1'b1;
                end
            end else if (hit(paddr_i, adc_seq_pkg::INJ_OFF)) begin
                inj_chan_d = pwdata_i[5:0];
                if (pwdata_i[adc_seq_pkg::INJ_GO_BIT] && ctrl_q.enable) begin
                    inj_pend_d = 1'b1;
                end
            end else if (hit(paddr_i, adc_seq_pkg::SEQ_OFF)) begin
                if (pwdata_i[4:0] <= adc_seq_pkg::SEQ_LAST_POS) begin
                    seq_d[pwdata_i[4:0]] = pwdata_i[13:8];
                end
            end else if (hit(paddr_i, adc_seq_pkg::WDTHR_OFF)) begin
                thr_lo_d = pwdata_i[11:0];
                thr_hi_d = pwdata_i[27:16];
            end else if (hit(paddr_i, adc_seq_pkg::WDMASK_OFF)) begin
                wd_mask_d = pwdata_i[27:0];
            end else if (hit(paddr_i, adc_seq_pkg::STATUS_OFF)) begin
                st_clr = pwdata_i[3:0];
            end else if (hit(paddr_i, adc_seq_pkg::IMASK_OFF)) begin
                imask_d = pwdata_i[3:0];
            end else if (hit(paddr_i, adc_seq_pkg::ROUTE_OFF)) begin
                route_d = pwdata_i[1:0];
            end
        end
        // sticky flags, a new event beats a clear
        status_d = (status_q & ~st_clr) | st_set;
        // read data prepared in the setup cycle
        if (setup && !pwrite_i) begin
            if (hit(paddr_i, adc_seq_pkg::CTRL_OFF)) begin
                rdata_d = 32'(ctrl_q);
            end else if (hit(paddr_i, adc_seq_pkg::INJ_OFF)) begin
                rdata_d = {23'h00_0000, inj_pend_q, 2'h0, inj_chan_q};
            end else if (hit(paddr_i, adc_seq_pkg::SEQ_OFF)) begin
                rdata_d = {18'h0_0000, scan_act_q, chan_q, 2'h0, pos_q};
            end else if (hit(paddr_i, adc_seq_pkg::WDTHR_OFF)) begin
                rdata_d = {4'h0, thr_hi_q, 4'h0, thr_lo_q};
            end else if (hit(paddr_i, adc_seq_pkg::WDMASK_OFF)) begin
                rdata_d = {4'h0, wd_mask_q};
            end else if (hit(paddr_i, adc_seq_pkg::STATUS_OFF)) begin
                rdata_d = {28'h000_0000, status_q};
            end else if (hit(paddr_i, adc_seq_pkg::IMASK_OFF)) begin
                rdata_d = {28'h000_0000, imask_q};
            end else if (hit(paddr_i, adc_seq_pkg::DATA_OFF)) begin
                rdata_d = {20'h0_0000, data_q};
            end else if (hit(paddr_i, adc_seq_pkg::JDATA_OFF)) begin
                rdata_d = {20'h0_0000, jdata_q};
            end else if (hit(paddr_i, adc_seq_pkg::ROUTE_OFF)) begin
                rdata_d = {30'h0000_0000, route_q};
            end else if (hit(paddr_i, adc_seq_pkg::CAL0_OFF)) begin
                rdata_d = CAL_TS_WORD;
            end else if (hit(paddr_i, adc_seq_pkg::CAL1_OFF)) begin
                rdata_d = CAL_VREF_WORD;
            end else begin
                rdata_d = 32'h0000_0000;
                slverr_d = 1'b1;
            end
        end else if (setup) begin
            slverr_d = !(hit(paddr_i, adc_seq_pkg::CTRL_OFF) ||
                hit(paddr_i, adc_seq_pkg::INJ_OFF) ||
                hit(paddr_i, adc_seq_pkg::SEQ_OFF) ||
                hit(paddr_i, adc_seq_pkg::WDTHR_OFF) ||
                hit(paddr_i, adc_seq_pkg::WDMASK_OFF) ||
                hit(paddr_i, adc_seq_pkg::STATUS_OFF) ||
                hit(paddr_i, adc_seq_pkg::IMASK_OFF) ||
                hit(paddr_i, adc_seq_pkg::ROUTE_OFF));
        end else if (psel_i) begin
            slverr_d = slverr_q;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= adc_seq_pkg::ctrl_type'(adc_seq_pkg::CTRL_RST);
            st_q <= adc_seq_pkg::ST_IDLE;
            for (int i = 0; i < adc_seq_pkg::SEQ_DEPTH; i++) begin
                seq_q[i] <= 6'h00;
            end
            inj_chan_q <= 6'h00;
            thr_lo_q <= adc_seq_pkg::WDTHR_RST[11:0];
            thr_hi_q <= adc_seq_pkg::WDTHR_RST[27:16];
            wd_mask_q <= 28'h000_0000;
            status_q <= 4'h0;
            imask_q <= 4'h0;
            data_q <= 12'h000;
            jdata_q <= 12'h000;
            data_vld_q <= 1'b0;
            route_q <= 2'h0;
            reg_pend_q <= 1'b0;
            inj_pend_q <= 1'b0;
            scan_act_q <= 1'b0;
            cur_inj_q <= 1'b0;
            pos_q <= 5'h00;
            cnt_q <= 8'h00;
            pwr_q <= 1'b0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            chan_q <= 6'h00;
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            st_q <= st_d;
            seq_q <= seq_d;
            inj_chan_q <= inj_chan_d;
            thr_lo_q <= thr_lo_d;
            thr_hi_q <= thr_hi_d;
            wd_mask_q <= wd_mask_d;
            status_q <= status_d;
            imask_q <= imask_d;
            data_q <= data_d;
            jdata_q <= jdata_d;
            data_vld_q <= data_vld_d;
            route_q <= route_d;
            reg_pend_q <= reg_pend_d;
            inj_pend_q <= inj_pend_d;
            scan_act_q <= scan_act_d;
            cur_inj_q <= cur_inj_d;
            pos_q <= pos_d;
            cnt_q <= cnt_d;
            pwr_q <= pwr_d;
            start_q <= start_d;
            abort_q <= abort_d;
            chan_q <= chan_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence pwrup_s;
        (st_q == adc_seq_pkg::ST_PWRUP) ##19 (st_q == adc_seq_pkg::ST_PWRUP)
            ##1 (st_q == adc_seq_pkg::ST_START);
    endsequence

    inj_abort_a: assert property ((st_q == adc_seq_pkg::ST_WAIT) && !cur_inj_q
        && inj_pend_q && !conv_done_i |=> conv_abort_o ##1 conv_start_o
        && cur_inj_q) else $error("injection did not pre-empt");
    scan_resume_a: assert property (conv_start_o && !cur_inj_q |->
        conv_chan_o == seq_q[pos_q]) else $error("scan slot lost");
    awd_set_a: assert property ((st_q == adc_seq_pkg::ST_WAIT) && conv_done_i
        && (ctrl_q.wd_mode == adc_seq_pkg::WD_ALL) && !cur_inj_q
        && (conv_data_i > thr_hi_q) |=> status_q[adc_seq_pkg::ST_AWD])
        else $error("watchdog flag missing");
    awd_sticky_a: assert property (status_q[adc_seq_pkg::ST_AWD] &&
        !(wr && hit(paddr_i, adc_seq_pkg::STATUS_OFF)) |=>
        status_q[adc_seq_pkg::ST_AWD]) else $error("flag dropped");
    dma_req_a: assert property ((st_q == adc_seq_pkg::ST_WAIT) && conv_done_i
        && !cur_inj_q && ctrl_q.dma_en |=> dma_req_o && data_q == $past(
        conv_data_i)) else $error("dma request missing");
    pwrup_len_a: assert property ($rose(st_q == adc_seq_pkg::ST_PWRUP) |->
        pwrup_s) else $error("power-up wait wrong");
    auto_off_a: assert property ((st_q == adc_seq_pkg::ST_IDLE) &&
        ctrl_q.enable && ctrl_q.auto_off && !reg_pend_q && !inj_pend_q &&
        !scan_act_q |=> !adc_power_o) else $error("no auto-off");
    trig_start_a: assert property (ctrl_q.enable && ctrl_q.trig_en &&
        trig_i[ctrl_q.trig_sel] && (st_q == adc_seq_pkg::ST_IDLE) &&
        adc_power_o && !inj_pend_q && !scan_act_q |-> ##[1:3] conv_start_o)
        else $error("trigger ignored");
    cal_ro_a: assert property (setup && !pwrite_i &&
        hit(paddr_i, adc_seq_pkg::CAL0_OFF) |=> prdata_o == CAL_TS_WORD)
        else $error("calibration word wrong");
endmodule

// ### verif/adc_front_model.sv
// behavioural converter front end answering start, abort and channel
`timescale 1ns/1ps
module adc_front_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic conv_start_i,
    input wire logic conv_abort_i,
    input wire logic [5:0] conv_chan_i,
    input wire logic [7:0] lat_i,
    output logic conv_done_o,
    output logic [11:0] conv_data_o
);
    logic [7:0] cnt_q;
    logic [5:0] ch_q;
    // count down the conversion time, then hand back one result
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            ch_q <= 6'h00;
            conv_done_o <= 1'b0;
            conv_data_o <= 12'h000;
        end else begin
            conv_done_o <= 1'b0;
            conv_data_o <= ~conv_data_o; // not valid between results
            if (conv_abort_i) begin
                cnt_q <= 8'h00; // dropped, no result follows
            end else if (conv_start_i) begin
                cnt_q <= lat_i;
                ch_q <= conv_chan_i;
            end else if (cnt_q == 8'h01) begin
                cnt_q <= 8'h00;
                conv_done_o <= 1'b1;
                conv_data_o <= {ch_q, 6'h15};
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// ### verif/adc_sequencer_control_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_sequencer_control_bench;
    logic clk_sys_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0, cdata;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, serr, e, cs, ca, done, pwr, lp, rts, rvf, dreq, irq;
    logic dack = 0;
    logic [7:0] trig = '0, lat = 8'h04;
    logic [5:0] chan, chs[4] = '{6'h10, 6'h11, 6'h27, 6'h00};
    logic [31:0] wctl[5] = '{32'h0300_0005, 32'h9D00_0005, 32'h9900_0005,
        32'h0200_0005, 32'h0000_0005};
    logic wirq[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int err_total = 0, n_compared = 0;
    logic [5:0] seen_q[$];
    always #25 clk_sys_i = ~clk_sys_i;
    adc_sequencer_control #(.CAL_TS_WORD(32'h0A5A_0C3C)) dut (
        .clk_sys_i, .rst_i, .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(serr),
        .trig_i(trig), .conv_start_o(cs), .conv_abort_o(ca),
        .conv_chan_o(chan), .conv_done_i(done), .conv_data_i(cdata),
        .adc_power_o(pwr), .low_power_o(lp), .route_ts_o(rts),
        .route_vref_o(rvf), .dma_req_o(dreq), .dma_ack_i(dack), .irq_o(irq));
    adc_front_model conv (.clk_sys_i, .rst_i, .conv_start_i(cs),
        .conv_abort_i(ca), .conv_chan_i(chan), .lat_i(lat),
        .conv_done_o(done), .conv_data_o(cdata));
    // log every channel the converter is told to start
    always @(posedge clk_sys_i) if (cs === 1'b1) seen_q.push_back(chan);
    function automatic logic [31:0] ex(input logic [5:0] c);
        return {20'h0_0000, c, 6'h15};
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_i) penable <= 1;
        n = 0;
        do begin @(posedge clk_sys_i); n++; end while (pready !== 1 && n < 99);
        if (n >= 99) begin err_total++; results; end
        q = prdata; e = serr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wait_st(input int b);
        int n;
        n = 0;
        do begin apb(0, adc_seq_pkg::STATUS_OFF, 0); n++; end
        while (q[b] !== 1'b1 && n < 200);
        if (n >= 200) begin err_total++; results; end
    endtask
    // single conversion of slot 0 with a given control word
    task automatic one(input logic [5:0] c, input logic [31:0] ctl);
        apb(1, adc_seq_pkg::STATUS_OFF, 32'h0000_000F);
        apb(1, adc_seq_pkg::SEQ_OFF, {18'h0_0000, c, 8'h00});
        apb(1, adc_seq_pkg::CTRL_OFF, ctl);
        wait_st(0);
        chk("dma_req", dreq, ctl[4]);
        chk("chan", seen_q[$], c);
        apb(0, adc_seq_pkg::DATA_OFF, 0);
        chk("data", q, ex(c));
    endtask
    initial begin
        void'($urandom(8463));
        lat <= 8'($urandom_range(9, 1));
        chs[3] = 6'($urandom_range(39, 0));
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 0;
        apb(1, adc_seq_pkg::CAL0_OFF, 32'hFFFF_FFFF);
        apb(0, adc_seq_pkg::CAL0_OFF, 0);
        chk("cal0", q, 32'h0A5A_0C3C);
        apb(0, 12'h030, 0);
        chk("unmapped", {q[30:0], e}, 32'h0000_0001);
        apb(1, adc_seq_pkg::ROUTE_OFF, 32'h0000_0003);
        // the write lands on the edge the task returns at; look once settled
        @(negedge clk_sys_i);
        chk("route", {rts, rvf}, 2'b11);
        foreach (chs[i]) one(chs[i], 32'h0000_0005);
        apb(1, adc_seq_pkg::CTRL_OFF, 32'h0000_0061);
        repeat (4) @(posedge clk_sys_i);
        chk("power", {lp, pwr}, 2'b10);
        one(6'h07, 32'h0000_0065);
        apb(1, adc_seq_pkg::WDTHR_OFF, 32'h0200_0100);
        apb(1, adc_seq_pkg::WDMASK_OFF, 32'h0000_0001);
        apb(1, adc_seq_pkg::IMASK_OFF, 32'h0000_0008);
        foreach (wctl[i]) begin
            one(6'h27, wctl[i]);
            chk("irq", irq, wirq[i]);
        end
        for (int s = 0; s < 8; s++) begin
            apb(1, adc_seq_pkg::STATUS_OFF, 32'h0000_000F);
            apb(1, adc_seq_pkg::CTRL_OFF, 32'h0000_0081 | (s << 8));
            @(posedge clk_sys_i) trig <= ~(8'h01 << s);
            @(posedge clk_sys_i) trig <= 8'h00;
            repeat (40) @(posedge clk_sys_i);
            apb(0, adc_seq_pkg::STATUS_OFF, 0);
            chk("no_trig", q[0], 1'b0);
            @(posedge clk_sys_i) trig <= 8'h01 << s;
            @(posedge clk_sys_i) trig <= 8'h00;
            wait_st(0);
        end
        one(6'h09, 32'h0000_0015);
        // stale end-of-conversion flag would end the wait too early
        apb(1, adc_seq_pkg::STATUS_OFF, 32'h0000_000F);
        apb(1, adc_seq_pkg::CTRL_OFF, 32'h0000_0015);
        wait_st(0);
        @(posedge clk_sys_i) dack <= 1;
        @(posedge clk_sys_i) dack <= 0;
        @(posedge clk_sys_i);
        chk("dma_ack", dreq, 1'b0);
        lat <= 8'h28;
        apb(1, adc_seq_pkg::SEQ_OFF, 32'h0000_0300);
        apb(1, adc_seq_pkg::SEQ_OFF, 32'h0000_0501);
        apb(1, adc_seq_pkg::STATUS_OFF, 32'h0000_000F);
        seen_q.delete();
        apb(1, adc_seq_pkg::CTRL_OFF, 32'h0001_000D);
        repeat (10) @(posedge clk_sys_i);
        apb(1, adc_seq_pkg::INJ_OFF, 32'h0000_0111);
        wait_st(1);
        apb(0, adc_seq_pkg::JDATA_OFF, 0);
        chk("jdata", q, ex(6'h11));
        apb(0, adc_seq_pkg::DATA_OFF, 0);
        chk("scan_data", q, ex(6'h05));
        chk("order", {seen_q[0], seen_q[1], seen_q[2], seen_q[3]},
            {8'h00, 6'h03, 6'h11, 6'h03, 6'h05});
        results;
    end
endmodule
